// file: pin_select_pkg.sv
// Notes on behaviour
// - direction bit 0 output, 1 input
// - direction register resets to all ones
// - direction register read/write, bit and byte writes
// - analog function in output mode is prohibited
// - analog input, selected channel goes to converter
// - analog input, unselected channel not converted
// - amplifier input pins connect to enabled amplifier
// - amplifier output pins drive enabled amplifier output
// - digital use needs unselected channel; amplifier off on amp output pins
// - amplifier enables are control bits 3 and 7
// - config bit 0 analog, 1 digital, reset zero
// - channel select is 3 bits, upper bits zero
package pin_select_pkg;
    localparam logic [15:0] DIR_ADDR = 16'hFF22;
    localparam logic [15:0] CFG_ADDR = 16'hFF97;
    localparam logic [15:0] CHSEL_ADDR = 16'hFF0E;
    localparam logic [15:0] AMPCTL_ADDR = 16'hFF30;
    localparam logic [15:0] STATUS_ADDR = 16'hFF31;
    localparam logic [15:0] ERROR_ADDR = 16'hFF32;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CHSEL_RESET = 8'h00;
    localparam logic [7:0] AMPCTL_RESET = 8'h00;
    localparam logic [7:0] CHSEL_MASK = 8'h07;
    localparam int AMP0_EN_BIT = 7;
    localparam int AMP1_EN_BIT = 3;
    // pin roles: bit n set marks pin n
    localparam logic [7:0] AMP_IN_PINS = 8'hA5;
    localparam logic [7:0] AMP_OUT_PINS = 8'h42;
    // pins 0..4 belong to amplifier 0, 5..7 to amplifier 1
    localparam logic [7:0] AMP1_PINS = 8'hE0;
    localparam logic [7:0] DATA_UNMAPPED = 8'h00;
endpackage

// file: reg_bus_if.sv
`timescale 1ns/1ns
interface reg_bus_if;
    logic [15:0] addr;
    logic [7:0] data;
    logic bit_we;
    logic [2:0] bit_idx;
    logic bit_val;
    logic byte_we;
    modport master(output addr, output data, output bit_we, output bit_idx, output bit_val,
        output byte_we);
    modport slave(input addr, input data, input bit_we, input bit_idx, input bit_val,
        input byte_we);
endinterface

// file: pin_byte_reg.sv
`timescale 1ns/1ns
module pin_byte_reg #(
    parameter logic [15:0] ADDR = 16'h0000,
    parameter logic [7:0] RESET = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    reg_bus_if.slave bus,
    output logic [7:0] o_value
);
    typedef struct packed {
        logic [7:0] value;
    } state_s;
    state_s state_r;
    state_s state_nxt;
    always_comb begin
        state_nxt = state_r;
        if (bus.addr == ADDR) begin
            if (bus.byte_we) begin
                state_nxt.value = bus.data & MASK;
            end else if (bus.bit_we) begin
                state_nxt.value[bus.bit_idx] = bus.bit_val;
                state_nxt.value = state_nxt.value & MASK;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= '{value: RESET};
        end else begin
            state_r <= state_nxt;
        end
    end
    assign o_value = state_r.value;
endmodule

// file: port2_pin_select.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
module port2_pin_select (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [15:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [7:0] i_port_latch,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic [7:0] o_port_out,
    output logic [7:0] o_port_oe,
    output logic [7:0] o_digital_in_en,
    output logic [7:0] o_adc_route,
    output logic [7:0] o_amp_in_connect,
    output logic [7:0] o_amp_out_drive,
    output logic [7:0] o_config_error,
    output logic o_any_error
);
    typedef struct packed {
        logic done;
        logic [31:0] rdata;
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] din;
        logic [7:0] adc;
        logic [7:0] ampin;
        logic [7:0] ampout;
        logic [7:0] err;
        logic anyerr;
    } state_s;
    state_s state_r;
    state_s state_nxt;
    reg_bus_if bus();
    logic [7:0] dir;
    logic [7:0] cfg;
    logic [7:0] chsel;
    logic [7:0] ampctl;
    logic [7:0] sel_onehot;
    logic [7:0] amp_en;
    logic [7:0] err_c;
    logic [7:0] rd_byte;
    logic wr_go;
    // one wait cycle per access; the write lands on the releasing edge
    assign wr_go = i_write && state_r.done;
    assign bus.addr = i_address;
    assign bus.data = i_writedata[7:0];
    // single-bit writes come as byte lane 1 carrying index and value
    assign bus.byte_we = wr_go && i_byteenable[0];
    assign bus.bit_we = wr_go && !i_byteenable[0] && i_byteenable[1];
    assign bus.bit_idx = i_writedata[10:8];
    assign bus.bit_val = i_writedata[15];
    pin_byte_reg #(.ADDR(pin_select_pkg::DIR_ADDR), .RESET(pin_select_pkg::DIR_RESET),
        .MASK(8'hFF)) u_dir (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
        .o_value(dir));
    pin_byte_reg #(.ADDR(pin_select_pkg::CFG_ADDR), .RESET(pin_select_pkg::CFG_RESET),
        .MASK(8'hFF)) u_cfg (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
        .o_value(cfg));
    pin_byte_reg #(.ADDR(pin_select_pkg::CHSEL_ADDR), .RESET(pin_select_pkg::CHSEL_RESET),
        .MASK(pin_select_pkg::CHSEL_MASK)) u_chsel (.i_clk(i_clk), .i_resetn(i_resetn),
        .bus(bus), .o_value(chsel));
    pin_byte_reg #(.ADDR(pin_select_pkg::AMPCTL_ADDR), .RESET(pin_select_pkg::AMPCTL_RESET),
        .MASK(8'hFF)) u_ampctl (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
        .o_value(ampctl));
    always_comb begin
        sel_onehot = 8'h00;
        sel_onehot[chsel[2:0]] = 1'b1;
        // amplifier enables fan out to the pins each amplifier owns
        amp_en = (pin_select_pkg::AMP1_PINS & {8{ampctl[pin_select_pkg::AMP1_EN_BIT]}})
            | (~pin_select_pkg::AMP1_PINS & {8{ampctl[pin_select_pkg::AMP0_EN_BIT]}});
    end
    always_comb begin
        rd_byte = pin_select_pkg::DATA_UNMAPPED;
        unique case (i_address)
            pin_select_pkg::DIR_ADDR: rd_byte = dir;
            pin_select_pkg::CFG_ADDR: rd_byte = cfg;
            pin_select_pkg::CHSEL_ADDR: rd_byte = chsel;
            pin_select_pkg::AMPCTL_ADDR: rd_byte = ampctl;
            pin_select_pkg::STATUS_ADDR: rd_byte = state_r.adc;
            pin_select_pkg::ERROR_ADDR: rd_byte = state_r.err;
            default: rd_byte = pin_select_pkg::DATA_UNMAPPED;
        endcase
    end
    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_pin
            logic analog;
            logic is_in;
            logic selected;
            logic amp_out_pin;
            logic amp_in_pin;
            assign analog = !cfg[n];
            assign is_in = dir[n];
            assign selected = sel_onehot[n];
            assign amp_out_pin = pin_select_pkg::AMP_OUT_PINS[n];
            assign amp_in_pin = pin_select_pkg::AMP_IN_PINS[n];
            // analog in output mode, or digital while selected or driven by amp
            assign err_c[n] = (analog && !is_in)
                || (!analog && selected)
                || (!analog && amp_out_pin && amp_en[n]);
        end
    endgenerate
    always_comb begin
        state_nxt = state_r;
        state_nxt.done = (i_read || i_write) && !state_r.done;
        state_nxt.rdata = {24'h000000, rd_byte};
        state_nxt.err = err_c;
        state_nxt.anyerr = |err_c;
        for (int k = 0; k < 8; k++) begin
            // prohibited settings never drive the pin
            state_nxt.oe[k] = !dir[k] && cfg[k] && !err_c[k];
            state_nxt.out[k] = state_nxt.oe[k] && i_port_latch[k];
            state_nxt.din[k] = dir[k] && cfg[k] && !err_c[k];
            state_nxt.adc[k] = !cfg[k] && dir[k] && sel_onehot[k];
            state_nxt.ampin[k] = !cfg[k] && dir[k] && amp_en[k]
                && pin_select_pkg::AMP_IN_PINS[k];
            state_nxt.ampout[k] = !cfg[k] && dir[k] && amp_en[k]
                && pin_select_pkg::AMP_OUT_PINS[k];
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign o_readdata = state_r.rdata;
    assign o_waitrequest = !state_r.done;
    assign o_port_out = state_r.out;
    assign o_port_oe = state_r.oe;
    assign o_digital_in_en = state_r.din;
    assign o_adc_route = state_r.adc;
    assign o_amp_in_connect = state_r.ampin;
    assign o_amp_out_drive = state_r.ampout;
    assign o_config_error = state_r.err;
    assign o_any_error = state_r.anyerr;
endmodule

// file: pin_select_props.sv
`timescale 1ns/1ns
module pin_select_props (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic [7:0] o_port_out,
    input wire logic [7:0] o_port_oe,
    input wire logic [7:0] o_adc_route,
    input wire logic [7:0] o_amp_in_connect,
    input wire logic [7:0] o_amp_out_drive,
    input wire logic [7:0] o_config_error,
    input wire logic o_any_error
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_req;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_ack;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    property p_handshake;
        s_req |=> s_ack;
    endproperty
    property p_idle;
        !(i_read || i_write) |=> o_waitrequest;
    endproperty
    property p_upper;
        !o_waitrequest |-> o_readdata[31:8] == 24'h000000;
    endproperty
    property p_oe_err;
        (o_port_oe & o_config_error) == 8'h00;
    endproperty
    property p_gate;
        (o_port_out & ~o_port_oe) == 8'h00;
    endproperty
    property p_any;
        o_any_error == (|o_config_error);
    endproperty
    property p_route;
        $onehot0(o_adc_route);
    endproperty
    property p_ain;
        (o_amp_in_connect & ~pin_select_pkg::AMP_IN_PINS) == 8'h00;
    endproperty
    property p_aout;
        (o_amp_out_drive & ~pin_select_pkg::AMP_OUT_PINS) == 8'h00;
    endproperty
    a_handshake: assert property (p_handshake) else $error("answer not one wait cycle");
    a_idle: assert property (p_idle) else $error("waitrequest low without request");
    a_upper: assert property (p_upper) else $error("readdata upper bits set");
    a_oe_err: assert property (p_oe_err) else $error("buffer on for bad pin");
    a_gate: assert property (p_gate) else $error("pin driven with buffer off");
    a_any: assert property (p_any) else $error("summary error wrong");
    a_route: assert property (p_route) else $error("two pins routed");
    a_ain: assert property (p_ain) else $error("amp input on wrong pin");
    a_aout: assert property (p_aout) else $error("amp output on wrong pin");
endmodule
bind port2_pin_select pin_select_props chk_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_port_out(o_port_out), .o_port_oe(o_port_oe),
    .o_adc_route(o_adc_route), .o_amp_in_connect(o_amp_in_connect),
    .o_amp_out_drive(o_amp_out_drive), .o_config_error(o_config_error),
    .o_any_error(o_any_error));

// file: port2_analog_digital_pin_select_tb_top.sv
`timescale 1ns/1ns
module port2_analog_digital_pin_select_tb_top;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [15:0] i_address = 16'h0000;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h00000000;
    logic [3:0] i_byteenable = 4'h0;
    logic [7:0] i_port_latch = 8'hA5;
    logic [31:0] o_readdata, q;
    logic o_waitrequest, o_any_error;
    logic [7:0] o_port_out, o_port_oe, o_digital_in_en, o_adc_route;
    logic [7:0] o_amp_in_connect, o_amp_out_drive, o_config_error;
    int n_mismatch = 0;
    int samples_checked = 0;
    typedef struct packed {logic [7:0] dir, cfg, ch, amp, oe, route, ain, aout, err, din;} row_s;
    // dir, config, channel, amp control, then expected oe, route, amp in, amp out, error, din
    // row 4 mixes analog pins in output mode with a digital pin under a live amp output
    row_s rows [6] = '{
        '{8'hFF, 8'h00, 8'h02, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00},
        '{8'hFF, 8'h00, 8'h01, 8'h88, 8'h00, 8'h02, 8'hA5, 8'h42, 8'h00, 8'h00},
        '{8'h00, 8'hFF, 8'h04, 8'h00, 8'hEF, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00},
        '{8'h0F, 8'hF0, 8'h06, 8'h80, 8'hB0, 8'h00, 8'h05, 8'h02, 8'h40, 8'h00},
        '{8'h0F, 8'h4F, 8'h05, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h0F},
        '{8'hFF, 8'h00, 8'h07, 8'h08, 8'h00, 8'h80, 8'hA0, 8'h40, 8'h00, 8'h00}};
    always #25 i_clk = ~i_clk;
    port2_pin_select uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .i_port_latch(i_port_latch), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .o_port_out(o_port_out), .o_port_oe(o_port_oe),
        .o_digital_in_en(o_digital_in_en), .o_adc_route(o_adc_route),
        .o_amp_in_connect(o_amp_in_connect), .o_amp_out_drive(o_amp_out_drive),
        .o_config_error(o_config_error), .o_any_error(o_any_error));
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // held until waitrequest sampled low; one idle edge keeps strobes from double assignment
    task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int k;
        k = 0;
        i_read <= rd;
        i_write <= !rd;
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 20);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
        if (k >= 20) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b0, a, {24'h000000, d}, 4'h1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        bus(1'b1, a, 32'h00000000, 4'h0);
        chk("readdata", {24'h000000, e}, q);
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        foreach (rows[i]) begin
            wr(pin_select_pkg::DIR_ADDR, rows[i].dir);
            wr(pin_select_pkg::CFG_ADDR, rows[i].cfg);
            wr(pin_select_pkg::CHSEL_ADDR, rows[i].ch);
            wr(pin_select_pkg::AMPCTL_ADDR, rows[i].amp);
            repeat (3) @(posedge i_clk);
            chk("oe", 32'(rows[i].oe), 32'(o_port_oe));
            chk("out", 32'(rows[i].oe & 8'hA5), 32'(o_port_out));
            chk("route", 32'(rows[i].route), 32'(o_adc_route));
            chk("amp_in", 32'(rows[i].ain), 32'(o_amp_in_connect));
            chk("amp_out", 32'(rows[i].aout), 32'(o_amp_out_drive));
            chk("error", 32'(rows[i].err), 32'(o_config_error));
            chk("any", 32'(|rows[i].err), 32'(o_any_error));
            chk("din", 32'(rows[i].din), 32'(o_digital_in_en));
        end
        wr(pin_select_pkg::DIR_ADDR, 8'hFF);
        bus(1'b0, pin_select_pkg::DIR_ADDR, 32'h00000200, 4'h2);
        rd(pin_select_pkg::DIR_ADDR, 8'hFB);
        wr(pin_select_pkg::CHSEL_ADDR, 8'hFF);
        rd(pin_select_pkg::CHSEL_ADDR, 8'h07);
        wr(16'h1234, 8'h5A);
        rd(16'h1234, 8'h00);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("wait", 32'h00000001, 32'(o_waitrequest));
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk("route", 32'h00000001, 32'(o_adc_route));
        chk("oe", 32'h00000000, 32'(o_port_oe));
        rd(pin_select_pkg::STATUS_ADDR, 8'h01);
        rd(pin_select_pkg::ERROR_ADDR, 8'h00);
        rd(pin_select_pkg::DIR_ADDR, 8'hFF);
        rd(pin_select_pkg::CFG_ADDR, 8'h00);
        rd(pin_select_pkg::CHSEL_ADDR, 8'h00);
        end_sim();
    end
endmodule
